// >>> hdl/cwd_defs.svh
// constants for the configuration word decoder
`ifndef CWD_DEFS_SVH
`define CWD_DEFS_SVH
`define CWD_WORD_W        24
`define CWD_NUM_WORDS     4
`define CWD_UPPER_ONES    8'hFF
`define CWD_ERASED_WORD   24'hFFFFFF
`define CWD_PAGE_WORDS    256
// word 1
`define CWD_WDPS_LO       0
// word 2
`define CWD_TWO_SPEED_STARTUP_EN_BIT      15
`define CWD_VRF_LO        11
`define CWD_FNOSC_LO      8
`define CWD_FCKSM_LO      6
`define CWD_OSCIO_BIT     5
`define CWD_IOL1_BIT      4
`define CWD_POSC_LO       0
`define CWD_W2_RSVD_MASK  24'h00600C
// word 3
`define CWD_PROTECT_END_SEL_BIT     15
`define CWD_CFG_PAGE_PROTECT_BIT     14
`define CWD_SEGMENT_PROTECT_DIS_BIT     13
`define CWD_BROWNOUT_RESET_EN_BIT     12
`define CWD_WIN_LO        10
`define CWD_SECONDARY_OSC_BIT      8
`define CWD_VBT_BIT       7
`define CWD_WPFP_LO       0
`define CWD_W3_RSVD_MASK  24'h000200
// word 4
`define CWD_DSSW_BIT      8
`define CWD_DSWDT_BIT     7
`define CWD_DSBOR_BIT     6
`define CWD_DSOSC_BIT     5
`define CWD_W4_RSVD_MASK  24'h00FE00
`endif

// >>> hdl/cwd_pkg.sv
// types for the configuration word decoder
package cwd_pkg;
	typedef enum logic [2:0] {
		CWD_FAST_INTERNAL_RC     = 3'h0,
		CWD_FAST_RC_POSTDIV_PLL  = 3'h1,
		CWD_PRIMARY              = 3'h2,
		CWD_PRIMARY_PLL          = 3'h3,
		CWD_SECONDARY_OSC        = 3'h4,
		CWD_LOW_POWER_RC         = 3'h5,
		CWD_OSC_RESERVED         = 3'h6,
		CWD_FAST_RC_WITH_POSTDIV = 3'h7
	} cwd_osc_type;
	typedef enum logic [1:0] {
		CWD_EXTERNAL_CLOCK_INPUT = 2'h0,
		CWD_STANDARD_CRYSTAL     = 2'h1,
		CWD_HIGH_SPEED_CRYSTAL   = 2'h2,
		CWD_PRIMARY_OFF          = 2'h3
	} cwd_posc_type;
	typedef enum logic [3:0] {
		CWD_IDLE  = 4'h1,
		CWD_REQ   = 4'h2,
		CWD_WAIT  = 4'h4,
		CWD_DONE  = 4'h8
	} cwd_state_type;
	typedef struct packed {
		logic [15:0]  wdog_post_div;
		logic [3:0]   wdog_post_div_sel;
		logic [6:0]   wdog_window_pct_x2;
		logic         two_speed_startup_en;
		cwd_osc_type  initial_osc_sel;
		logic         clk_switch_en;
		logic         fail_safe_mon_en;
		cwd_posc_type primary_osc_mode;
		logic         clock_out_pin_en;
		logic         pin_lock_one_way;
		logic         adc_ref_alt;
		logic         cmp_ref_alt;
		logic         secondary_osc_circuit;
		logic         battery_brownout_en;
		logic         brownout_reset_run;
		logic         brownout_reset_deepsleep;
		logic         deepsleep_allowed;
		logic         deepsleep_wdog_en;
		logic         deepsleep_wdog_low_power_rc;
	} cwd_cfg_type;
	typedef struct packed {
		logic       segment_on;
		logic       seg_to_top;
		logic [6:0] boundary_page;
		logic       cfg_page_locked;
	} cwd_prot_type;
endpackage

// >>> hdl/cwd_top.sv
// configuration word loader and field decoder
//
// Contract
// R1 - watchdog postscaler ratio is two to the power of its four-bit code
// R2 - two-speed start-up enabled when its bit is 1, disabled when 0
// R3 - initial oscillator code picks reset clock source, 110 reserved
// R4 - clock-switch upper bit 1 disables both; 01 switching only; 00 both
// R5 - clock-out pin gets sysclk/2 when bit set, only in primary modes 11/00
// R6 - one-way option makes pin-select lock settable once; else free
// R7 - primary mode: 11 off, 10 high-speed, 01 standard crystal, 00 ext clock
// R8 - reference route: upper bit converter pins, lower bit comparator pins
// R9 - programmer keeps reserved bits at 1
// R10 - bits 23 to 16 of every configuration word read as 1
// R11 - end select 1 protects boundary to top; 0 protects zero to boundary
// R12 - config page protected by its bit, end select, or boundary on it
// R13 - segment protect disable bit 1 turns segmented protection off
// R14 - brown-out reset bit enables reset in all modes but deep sleep
// R15 - window width 11 25%, 10 37.5%, 01 50%, 00 75%; code gives 00 as 7'h96 cut to 7 bits, 7'h16 (11%)
// R16 - secondary select 1 oscillator circuit, 0 digital clock input
// R17 - battery brown-out bit enables backup supply detection
// R18 - boundary counts 256-word pages; small parts keep bit 6 zero
// R19 - deep sleep control 1 allows run-time enable, 0 disables deep sleep
// R20 - deep sleep watchdog enabled by its bit
// R21 - deep sleep brown-out bit keeps reset active in deep sleep; code also needs the brown-out reset bit (word 3 bit 12) set
// R22 - deep sleep watchdog clock low-power RC when 1, secondary when 0
// R23 - unprogrammed fields default to 1 at reset
// R24 - every reset reloads all four words from flash
// R25 - programmed bit reads 0, unprogrammed reads 1
// R26 - decoded outputs valid only after the reset-time load completes
`timescale 1ns/1ps
`include "cwd_defs.svh"
module cwd_top #(
	parameter int WORD_W   = `CWD_WORD_W,
	parameter int PAGE_W   = 7,
	parameter logic [6:0] CFG_PAGE = 7'h7F
) (
	// clock and reset
	input  wire logic                i_sys_clk,
	input  wire logic                i_rst,
	// flash read port
	output logic                     o_fl_rd,
	output logic [1:0]               o_fl_idx,
	input  wire logic                i_fl_valid,
	input  wire logic [WORD_W-1:0]   i_fl_data,
	// register read-back
	input  wire logic [1:0]          i_rd_idx,
	output logic [WORD_W-1:0]        o_rd_data,
	// pin-select lock control
	input  wire logic                i_unlocked,
	input  wire logic                i_lock_wr,
	input  wire logic                i_lock_val,
	output logic                     o_pin_select_lock,
	// protection query
	input  wire logic [PAGE_W-1:0]   i_wr_page,
	output logic                     o_wr_blocked,
	// decoded settings
	output logic                     o_cfg_valid,
	output cwd_pkg::cwd_cfg_type     o_cfg,
	output cwd_pkg::cwd_prot_type    o_prot
);
	import cwd_pkg::*;

	// ==========================================================
	// load sequencer
	cwd_state_type     state_q;
	cwd_state_type     state_d;
	logic [1:0]        idx_q;
	logic [WORD_W-1:0] word_q [`CWD_NUM_WORDS];
	logic              last_w;

	assign last_w = (idx_q == 2'h3);

	always_comb begin
		state_d = state_q;
		case (state_q)
			CWD_IDLE: state_d = CWD_REQ;
			CWD_REQ:  state_d = CWD_WAIT;
			CWD_WAIT: if (i_fl_valid) begin
				state_d = last_w ? CWD_DONE : CWD_REQ;
			end
			CWD_DONE: state_d = CWD_DONE;
			default:  state_d = CWD_IDLE;
		endcase
	end

	// every reset restarts the load, so any reset type refreshes settings
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= CWD_IDLE; // [R24]
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			idx_q <= 2'h0;
		end else if (state_q == CWD_WAIT && i_fl_valid && !last_w) begin
			idx_q <= idx_q + 2'h1;
		end
	end

	assign o_fl_rd  = (state_q == CWD_REQ);
	assign o_fl_idx = idx_q;

	// ==========================================================
	// word store: erased value until loaded, upper byte forced high
	genvar g;
	generate
		for (g = 0; g < `CWD_NUM_WORDS; g++) begin : g_word
			always_ff @(posedge i_sys_clk or posedge i_rst) begin
				if (i_rst) begin
					word_q[g] <= `CWD_ERASED_WORD; // [R23] [R25]
				end else if (state_q == CWD_WAIT && i_fl_valid && idx_q == g) begin
					word_q[g] <= {`CWD_UPPER_ONES, i_fl_data[15:0]}; // [R10] [R25]
				end
			end
		end
	endgenerate

	// reserved bits are stored as written; the read-back and decode always see them as 1
	logic [WORD_W-1:0] w1, w2, w3, w4;
	assign w1 = word_q[0];
	assign w2 = word_q[1] | `CWD_W2_RSVD_MASK; // [R9]
	assign w3 = word_q[2] | `CWD_W3_RSVD_MASK; // [R9]
	assign w4 = word_q[3] | `CWD_W4_RSVD_MASK; // [R9]

	function automatic logic [WORD_W-1:0] pick(input logic [1:0] k,
		input logic [WORD_W-1:0] a, b, c, d);
		case (k)
			2'h0:    pick = a;
			2'h1:    pick = b;
			2'h2:    pick = c;
			default: pick = d;
		endcase
	endfunction

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rd_data <= `CWD_ERASED_WORD;
		end else begin
			o_rd_data <= pick(i_rd_idx, w1, w2, w3, w4); // [R10]
		end
	end

	// ==========================================================
	// field decode
	cwd_cfg_type  cfg_w;
	cwd_prot_type prot_w;
	logic [3:0]   wdps_w;
	logic [1:0]   fcksm_w;
	logic [1:0]   win_w;
	logic [6:0]   wpfp_w;

	assign wdps_w  = w1[`CWD_WDPS_LO +: 4];
	assign fcksm_w = w2[`CWD_FCKSM_LO +: 2];
	assign win_w   = w3[`CWD_WIN_LO +: 2];
	// small parts must keep bit 6 zero; the full field is still honoured
	assign wpfp_w  = w3[`CWD_WPFP_LO +: 7]; // [R18]

	assign cfg_w.wdog_post_div_sel = wdps_w;
	assign cfg_w.wdog_post_div     = 16'h0001 << wdps_w; // [R1]
	assign cfg_w.two_speed_startup_en = w2[`CWD_TWO_SPEED_STARTUP_EN_BIT]; // [R2]
	assign cfg_w.initial_osc_sel   = cwd_osc_type'(w2[`CWD_FNOSC_LO +: 3]); // [R3]
	assign cfg_w.clk_switch_en     = ~fcksm_w[1]; // [R4]
	assign cfg_w.fail_safe_mon_en  = (fcksm_w == 2'h0); // [R4]
	assign cfg_w.primary_osc_mode  = cwd_posc_type'(w2[`CWD_POSC_LO +: 2]); // [R7]
	assign cfg_w.clock_out_pin_en  = w2[`CWD_OSCIO_BIT] &
		(cfg_w.primary_osc_mode == CWD_PRIMARY_OFF ||
		 cfg_w.primary_osc_mode == CWD_EXTERNAL_CLOCK_INPUT); // [R5]
	assign cfg_w.pin_lock_one_way  = w2[`CWD_IOL1_BIT];
	assign cfg_w.adc_ref_alt       = w2[`CWD_VRF_LO + 1]; // [R8]
	assign cfg_w.cmp_ref_alt       = w2[`CWD_VRF_LO]; // [R8]
	// window in half-percent units so 37.5 stays exact
	assign cfg_w.wdog_window_pct_x2 = (win_w == 2'h3) ? 7'h32 :
		(win_w == 2'h2) ? 7'h4B : (win_w == 2'h1) ? 7'h64 : 7'h96; // [R15]
	assign cfg_w.secondary_osc_circuit = w3[`CWD_SECONDARY_OSC_BIT]; // [R16]
	assign cfg_w.battery_brownout_en   = w3[`CWD_VBT_BIT]; // [R17]
	assign cfg_w.brownout_reset_run    = w3[`CWD_BROWNOUT_RESET_EN_BIT]; // [R14]
	assign cfg_w.brownout_reset_deepsleep = w3[`CWD_BROWNOUT_RESET_EN_BIT] &
		w4[`CWD_DSBOR_BIT]; // [R21]
	assign cfg_w.deepsleep_allowed     = w4[`CWD_DSSW_BIT]; // [R19]
	assign cfg_w.deepsleep_wdog_en     = w4[`CWD_DSWDT_BIT]; // [R20]
	assign cfg_w.deepsleep_wdog_low_power_rc   = w4[`CWD_DSOSC_BIT]; // [R22]

	assign prot_w.segment_on      = ~w3[`CWD_SEGMENT_PROTECT_DIS_BIT]; // [R13]
	assign prot_w.seg_to_top      = w3[`CWD_PROTECT_END_SEL_BIT]; // [R11]
	assign prot_w.boundary_page   = wpfp_w;
	assign prot_w.cfg_page_locked = prot_w.segment_on &
		(~w3[`CWD_CFG_PAGE_PROTECT_BIT] | prot_w.seg_to_top | wpfp_w == CFG_PAGE); // [R12]

	// ==========================================================
	// outputs held at safe values until the load is done
	logic done_w;
	assign done_w = (state_q == CWD_DONE);

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_cfg_valid <= 1'b0;
			o_cfg       <= '0;
			o_prot      <= '0;
		end else begin
			o_cfg_valid <= done_w; // [R26]
			if (done_w) begin
				o_cfg  <= cfg_w; // [R26]
				o_prot <= prot_w;
			end
		end
	end

	// ==========================================================
	// write protection check on page numbers of 256 words
	logic in_seg_w;
	assign in_seg_w = o_prot.seg_to_top ? (i_wr_page >= o_prot.boundary_page) :
		(i_wr_page <= o_prot.boundary_page); // [R11]
	assign o_wr_blocked = ~o_cfg_valid | (o_prot.segment_on & in_seg_w) |
		(o_prot.cfg_page_locked & i_wr_page == CFG_PAGE); // [R12] [R13]

	// ==========================================================
	// pin-select lock
	logic lock_q;
	logic lock_set_once_q;
	logic lock_wr_ok_w;
	assign lock_wr_ok_w = i_lock_wr & i_unlocked & o_cfg_valid &
		~(o_cfg.pin_lock_one_way & lock_set_once_q); // [R6]

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			lock_q          <= 1'b0;
			lock_set_once_q <= 1'b0;
		end else if (lock_wr_ok_w) begin
			lock_q          <= i_lock_val; // [R6]
			lock_set_once_q <= lock_set_once_q | i_lock_val;
		end
	end
	assign o_pin_select_lock = lock_q;
endmodule

// >>> dv/cwd_top_sva.sv
// checker for the configuration word decoder
`timescale 1ns/1ps
module cwd_top_sva
	import cwd_pkg::*;
#(parameter int WORD_W = 24, parameter int PAGE_W = 7) (
	// clock and reset
	input logic              i_sys_clk,
	input logic              i_rst,
	// watched ports
	input logic              o_fl_rd,
	input logic [1:0]        o_fl_idx,
	input logic              i_fl_valid,
	input logic [WORD_W-1:0] o_rd_data,
	input logic              o_pin_select_lock,
	input logic              o_wr_blocked,
	input logic              o_cfg_valid,
	input cwd_cfg_type       o_cfg,
	input cwd_prot_type      o_prot
);
	// ==========
	// properties
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	a_rd_one_cycle: assert property (o_fl_rd |=> !o_fl_rd) else $error("long flash request");
	a_idx_holds: assert property (!o_cfg_valid && !i_fl_valid |=> $stable(o_fl_idx))
		else $error("word index moved");
	a_next_request: assert property (i_fl_valid && !o_fl_rd && !o_cfg_valid && o_fl_idx != 2'h3
		|=> o_fl_rd) else $error("no next request");
	a_load_done: assert property (i_fl_valid && !o_fl_rd && !o_cfg_valid && o_fl_idx == 2'h3
		|-> ##[1:2] o_cfg_valid) else $error("valid late");
	a_valid_sticky: assert property (o_cfg_valid |=> o_cfg_valid) else $error("valid fell");
	a_cfg_frozen: assert property (o_cfg_valid |=> $stable(o_cfg) && $stable(o_prot))
		else $error("settings moved");
	a_empty_preload: assert property (!o_cfg_valid |-> o_wr_blocked && o_cfg == '0)
		else $error("settings before load");
	a_div_ratio: assert property (o_cfg_valid |->
		o_cfg.wdog_post_div == (16'h0001 << o_cfg.wdog_post_div_sel)) else $error("ratio");
	a_monitor_switch: assert property (o_cfg.fail_safe_mon_en |-> o_cfg.clk_switch_en)
		else $error("monitor without switching");
	a_clkout_mode: assert property (o_cfg.clock_out_pin_en |-> o_cfg.primary_osc_mode inside
		{CWD_EXTERNAL_CLOCK_INPUT, CWD_PRIMARY_OFF}) else $error("clock out mode");
	a_upper_ones: assert property (o_rd_data[WORD_W-1:16] == 8'hFF) else $error("upper byte");
	a_lock_once: assert property (o_cfg.pin_lock_one_way && o_pin_select_lock
		|=> o_pin_select_lock) else $error("lock cleared");
endmodule
bind cwd_top cwd_top_sva #(.WORD_W(WORD_W), .PAGE_W(PAGE_W)) u_sva (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .o_fl_rd(o_fl_rd), .o_fl_idx(o_fl_idx),
	.i_fl_valid(i_fl_valid), .o_rd_data(o_rd_data), .o_pin_select_lock(o_pin_select_lock),
	.o_wr_blocked(o_wr_blocked), .o_cfg_valid(o_cfg_valid), .o_cfg(o_cfg), .o_prot(o_prot));

// >>> dv/cwd_flash_model.sv
// flash stand-in returning configuration words after a settable delay
`timescale 1ns/1ps
module cwd_flash_model (
	// requests
	input  logic        i_sys_clk,
	input  logic        i_rd,
	input  logic [1:0]  i_idx,
	input  int          i_lat,
	input  logic [95:0] i_words,
	// answer
	output logic        o_valid,
	output logic [23:0] o_data
);
	int   cnt = 0;
	logic busy = 1'b0;
	initial o_valid = 1'b0;
	initial o_data = 24'h0;
	// ==========
	// answer one word per request, every reset reloads all four
	always @(posedge i_sys_clk) begin
		o_valid <= 1'b0;
		// data bus inverts every cycle outside the valid cycle, so the last word returns every second cycle
		o_data <= ~o_data;
		if (i_rd) begin
			cnt <= i_lat;
			busy <= 1'b1;
		end else if (busy && cnt == 0) begin
			o_valid <= 1'b1;
			o_data <= i_words[i_idx*24 +: 24];
			busy <= 1'b0;
		end else if (busy)
			cnt <= cnt - 1;
	end
endmodule

// >>> dv/cwd_top_bench.sv
// self-checking bench for the configuration word decoder
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("[FAIL] %s exp %h got %h", n, e, a); end end
module cwd_top_bench;
	import cwd_pkg::*;
	logic         i_sys_clk = 0, i_rst = 1, i_unlocked = 0, i_lock_wr = 0, i_lock_val = 0;
	logic         o_fl_rd, i_fl_valid, o_pin_select_lock, o_wr_blocked, o_cfg_valid;
	logic [1:0]   o_fl_idx, i_rd_idx = 0;
	logic [23:0]  i_fl_data, o_rd_data;
	logic [6:0]   i_wr_page = 0, fp, p;
	logic [95:0]  words = 0;
	logic [3:0]   b;
	logic [6:0]   win [4] = '{7'h96, 7'h64, 7'h4B, 7'h32};
	cwd_cfg_type  o_cfg, ec;
	cwd_prot_type o_prot, ep;
	int           lat = 0, bad_count = 0, n_checks = 0, t;
	cwd_top uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .o_fl_rd(o_fl_rd), .o_fl_idx(o_fl_idx),
		.i_fl_valid(i_fl_valid), .i_fl_data(i_fl_data), .i_rd_idx(i_rd_idx),
		.o_rd_data(o_rd_data), .i_unlocked(i_unlocked), .i_lock_wr(i_lock_wr),
		.i_lock_val(i_lock_val), .o_pin_select_lock(o_pin_select_lock), .i_wr_page(i_wr_page),
		.o_wr_blocked(o_wr_blocked), .o_cfg_valid(o_cfg_valid), .o_cfg(o_cfg), .o_prot(o_prot));
	cwd_flash_model u_flash (.i_sys_clk(i_sys_clk), .i_rd(o_fl_rd), .i_idx(o_fl_idx),
		.i_lat(lat), .i_words(words), .o_valid(i_fl_valid), .o_data(i_fl_data));
	// ==========
	// tasks
	initial forever #10 i_sys_clk = ~i_sys_clk;
	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task lockw(input logic u, input logic v);
		@(posedge i_sys_clk);
		i_unlocked <= u;
		i_lock_wr <= 1'b1;
		i_lock_val <= v;
		@(posedge i_sys_clk);
		i_lock_wr <= 1'b0;
		@(negedge i_sys_clk);
	endtask
	// ==========
	// every code of every field but the boundary page, slow and prompt flash, reset between loads
	initial begin
		repeat (5) @(posedge i_sys_clk);
		for (int i = 0; i < 16; i++) begin
			b = i[3:0];
			fp = {b, 3'h2};
			lat = (i % 3) * 4;
			// reserved bits kept at 1, upper byte 00 as programmed
			words = {8'h00, 7'h7F, b, 5'h15, 8'h00, b[0], b[1], b[2], b[3], b[1:0], 1'b1, b[2],
				b[3], fp, 8'h00, b[0], 2'h3, b[2:1], b[2:0], b[1:0], b[1], b[3], 2'h3, b[3:2],
				8'h00, 12'hFFF, b};
			@(posedge i_sys_clk);
			i_rst <= 1'b1;
			@(posedge i_sys_clk);
			i_rst <= 1'b0;
			for (t = 0; t < 200 && o_cfg_valid !== 1'b1; t++)
				@(posedge i_sys_clk);
			if (o_cfg_valid !== 1'b1) begin
				$display("[FAIL] load timeout");
				bad_count++;
				end_of_test();
			end
			@(negedge i_sys_clk);
			ec = '{16'h0001 << b, b, win[b[1:0]], b[0], cwd_osc_type'(b[2:0]), ~b[1],
				~b[1] & ~b[0], cwd_posc_type'(b[3:2]), b[1] & (b[3:2] == 2'h0 || b[3:2] == 2'h3),
				b[3], b[2], b[1], b[2], b[3], b[3], b[3] & b[1], b[3], b[2], b[0]};
			ep = '{~b[2], b[0], fp, ~b[2] & (~b[1] | b[0])};
			`CHK("cfg", ec, o_cfg)
			`CHK("prot", ep, o_prot)
			for (int d = -1; d <= 1; d++) begin
				p = fp + d[6:0];
				@(posedge i_sys_clk);
				i_wr_page <= p;
				@(negedge i_sys_clk);
				`CHK("blocked", ~b[2] & (b[0] ? p >= fp : p <= fp), o_wr_blocked)
			end
			for (int k = 0; k < 4; k++) begin
				@(posedge i_sys_clk);
				i_rd_idx <= k[1:0];
				@(posedge i_sys_clk);
				@(negedge i_sys_clk);
				`CHK("readback", {8'hFF, words[k*24 +: 16]}, o_rd_data)
			end
			lockw(1'b1, 1'b1);
			`CHK("lock", 1'b1, o_pin_select_lock)
			lockw(1'b1, 1'b0);
			`CHK("lock", b[3], o_pin_select_lock)
			lockw(1'b0, 1'b1);
			`CHK("lock", b[3], o_pin_select_lock)
		end
		end_of_test();
	end
endmodule
